// File: verilog/xbz_pkg.sv
// package: constants and carrier types for the x-bus buffer and zero-wait glue
package xbz_pkg;

    // ------------------------------------------------------------------
    // access classes and parallel port modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        XBZ_TGT_NONE = 3'h0,
        XBZ_TGT_CFG  = 3'h1,
        XBZ_TGT_PP   = 3'h2,
        XBZ_TGT_OTHR = 3'h3
    } xbz_target_t;

    typedef enum logic [1:0] {
        XBZ_PP_SPP   = 2'h0,
        XBZ_PP_EPP17 = 2'h1,
        XBZ_PP_EPP19 = 2'h2,
        XBZ_PP_ECP   = 2'h3
    } xbz_pp_mode_t;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int          XBZ_CFG1_ZWS_BIT  = 0;
    localparam int          XBZ_CFG1_XDB_BIT  = 4;
    localparam int          XBZ_PPC2_ZWS_BIT  = 3;
    localparam logic [7:0]  XBZ_CFG1_RST      = 8'h00;
    localparam logic [1:0]  XBZ_CFG1_SEL_W    = 2'h0;
    localparam int          XBZ_DATA_W        = 8;
    localparam int          XBZ_SYNC_STAGES   = 3;

    // ------------------------------------------------------------------
    // carrier structs
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] base_addr;
        logic [3:0] config_bits;
        logic       chip_select;
    } xbz_straps_t;

    typedef struct packed {
        logic       ring_n;
        logic       board_id_bit3;
        logic       board_id_bit1;
        logic [3:0] gpio_in;
        logic       gpio_e_in;
    } xbz_alt_in_t;

    typedef struct packed {
        logic       gen_chip_sel_a;
        logic       gen_chip_sel_b;
        logic [3:0] gpio_out;
        logic [3:0] gpio_oe;
        logic       infrared_select_a;
        logic       infrared_select_b;
        logic       gpio_e_out;
        logic       gpio_e_oe;
        logic       irsel_on_top;
    } xbz_alt_out_t;

endpackage : xbz_pkg

// File: verilog/xbz_sync.sv
// three-stage input synchroniser; a change counts once stages 2 and 3 agree
`timescale 1ns/1ns
`default_nettype none
module xbz_sync #(
    parameter int          W     = 1,
    parameter logic [31:0] RST_V = 32'h0000_0000
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // raw and filtered level
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    // ------------------------------------------------------------------
    // per-bit chain
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // stage1 feeds only stage2, so no metastable value escapes
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    stage1[i]   <= RST_V[i];
                    stage2[i]   <= RST_V[i];
                    stage3[i]   <= RST_V[i];
                    sync_out[i] <= RST_V[i];
                end else begin
                    stage1[i] <= async_in[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    if (stage2[i] == stage3[i]) begin
                        sync_out[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate

endmodule : xbz_sync
`default_nettype wire

// File: verilog/xbz_glue.sv
// x-bus data buffer pin mux, zero-wait control and reset strap capture
//
// Contract
// - zero_wait_n released on config register and spp or epp-1.9 port access.
// - zero_wait_n always driven low on parallel port access in ecp mode.
// - epp-1.7 port access asserts zero_wait_n only if second control bit 3.
// - other device accesses assert zero_wait_n per config-1 bit 0.
// - zero_wait_n is open drain active low; released means undriven.
// - buffer-select bit 1 gives shared pins to buffer select, read, data.
// - buffer-select bit 0 gives shared pins their alternate functions.
// - unselected function inputs are forced high internally.
// - data lines stay high-impedance while buffer chip select is inactive.
// - data lines driven during read command, received otherwise.
// - straps sampled during reset; pins return to normal use afterwards.
// - in epp mode the strobe pin carries the active-low write strobe.
// - buffer-select bit loads from the buffer strap at reset.
`timescale 1ns/1ns
`default_nettype none
module xbz_glue (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // isa access classification from the address decoder
    input  wire logic                 access_active,
    input  wire xbz_pkg::xbz_target_t access_target,
    input  wire xbz_pkg::xbz_pp_mode_t pp_mode,
    input  wire logic [7:0]           pp_second_control,
    input  wire logic [7:0]           cfg1_wr_data,
    input  wire logic                 cfg1_wr,
    // zero-wait open drain pin
    output logic                      zero_wait_n_out,
    output logic                      zero_wait_n_oe,
    // parallel port strobe pin
    input  wire logic                 pp_strobe_n,
    input  wire logic                 pp_write_n,
    output logic                      pp_strobe_pin_n,
    // shared pins 69 and 70 (inputs only)
    input  wire logic                 pin_cs_ring,
    input  wire logic                 pin_rd_id3,
    // shared pins 71..78
    input  wire logic [7:0]           pin_d_in,
    output logic      [7:0]           pin_d_out,
    output logic      [7:0]           pin_d_oe,
    // strap pins (sampled during reset)
    input  wire xbz_pkg::xbz_straps_t strap_pins,
    output xbz_pkg::xbz_straps_t      straps,
    // buffer data, internal side
    input  wire logic [7:0]           xbuf_rd_data,
    output logic      [7:0]           xbuf_wr_data,
    output logic                      xbuf_chip_sel_n,
    output logic                      xbuf_read_cmd_n,
    // alternate function internal side
    input  wire xbz_pkg::xbz_alt_out_t alt_out,
    output xbz_pkg::xbz_alt_in_t      alt_in,
    // configuration state
    output logic [7:0]                cfg1,
    output logic                      in_reset
);
    logic       xdb_en;
    logic       cs_sync;
    logic       rd_sync;
    logic [7:0] d_sync;
    logic       drive_data;
    logic       zws_assert;
    xbz_pkg::xbz_straps_t strap_sync;

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    // idle pins read high, matching the inactive level of the buffer strobes
    xbz_sync #(.W(10), .RST_V(32'h0000_03FF)) u_sync_pins (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in ({pin_cs_ring, pin_rd_id3, pin_d_in}),
        .sync_out ({cs_sync, rd_sync, d_sync})
    );

    // strap chain is never reset: it must carry pin levels while rst is held
    xbz_sync #(.W(7), .RST_V(32'h0000_0000)) u_sync_straps (
        .core_clk (core_clk),
        .rst      (1'b0),
        .async_in (strap_pins),
        .sync_out (strap_sync)
    );

    // ------------------------------------------------------------------
    // strap capture and configuration register 1
    // ------------------------------------------------------------------
    // strap sampling
    // straps track the pins while reset is held, then freeze at release
    always_ff @(posedge core_clk) begin
        if (rst) begin
            straps <= strap_sync;
        end
    end

    // flag so shared strap pins can keep their normal use after reset
    always_ff @(posedge core_clk) begin
        in_reset <= rst;
    end

    // buffer select load
    // bit 4 follows the buffer strap during reset; software may rewrite it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg1                        <= xbz_pkg::XBZ_CFG1_RST;
            cfg1[xbz_pkg::XBZ_CFG1_XDB_BIT] <= strap_sync.config_bits[1];
        end else if (cfg1_wr) begin
            cfg1 <= cfg1_wr_data;
        end
    end

    assign xdb_en = cfg1[xbz_pkg::XBZ_CFG1_XDB_BIT];

    // ------------------------------------------------------------------
    // zero-wait decision
    // ------------------------------------------------------------------
    // zws select
    always_comb begin
        zws_assert = 1'b0;
        if (access_active) begin
            case (access_target)
                xbz_pkg::XBZ_TGT_CFG: zws_assert = 1'b0;
                xbz_pkg::XBZ_TGT_PP: begin
                    case (pp_mode)
                        xbz_pkg::XBZ_PP_ECP:   zws_assert = 1'b1;
                        xbz_pkg::XBZ_PP_EPP17: zws_assert =
                            pp_second_control[xbz_pkg::XBZ_PPC2_ZWS_BIT];
                        default:               zws_assert = 1'b0;
                    endcase
                end
                xbz_pkg::XBZ_TGT_OTHR:
                    zws_assert = cfg1[xbz_pkg::XBZ_CFG1_ZWS_BIT];
                default: zws_assert = 1'b0;
            endcase
        end
    end

    // open drain drive
    // output level is always low; only the enable moves
    always_ff @(posedge core_clk) begin
        if (rst) begin
            zero_wait_n_oe <= 1'b0;
        end else begin
            zero_wait_n_oe <= zws_assert;
        end
    end

    assign zero_wait_n_out = 1'b0;

    // ------------------------------------------------------------------
    // parallel port strobe pin
    // ------------------------------------------------------------------
    // epp write strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pp_strobe_pin_n <= 1'b1;
        end else if (pp_mode == xbz_pkg::XBZ_PP_EPP17 ||
                     pp_mode == xbz_pkg::XBZ_PP_EPP19) begin
            pp_strobe_pin_n <= pp_write_n;
        end else begin
            pp_strobe_pin_n <= pp_strobe_n;
        end
    end

    // ------------------------------------------------------------------
    // buffer side inputs
    // ------------------------------------------------------------------
    // buffer inputs
    // unselected buffer strobes read inactive high
    assign xbuf_chip_sel_n = xdb_en ? cs_sync : 1'b1;
    assign xbuf_read_cmd_n = xdb_en ? rd_sync : 1'b1;

    assign drive_data = xdb_en && !cs_sync && !rd_sync;

    // received data registered; held high when buffer not selected
    always_ff @(posedge core_clk) begin
        if (rst) begin
            xbuf_wr_data <= 8'hFF;
        end else if (xdb_en && !cs_sync && rd_sync) begin
            xbuf_wr_data <= d_sync;
        end else if (!xdb_en) begin
            xbuf_wr_data <= 8'hFF;
        end
    end

    // ------------------------------------------------------------------
    // alternate side inputs
    // ------------------------------------------------------------------
    // alternate inputs
    always_comb begin
        alt_in               = '1;
        if (!xdb_en) begin
            alt_in.ring_n        = cs_sync;
            alt_in.board_id_bit3 = rd_sync;
            alt_in.board_id_bit1 = d_sync[7];
            alt_in.gpio_in       = d_sync[5:2];
            alt_in.gpio_e_in     = d_sync[6];
        end
    end

    // ------------------------------------------------------------------
    // shared pin drive
    // ------------------------------------------------------------------
    // pin mux
    // no shared pin is driven during reset so the strap pull levels stay readable
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_d_out <= 8'hFF;
            pin_d_oe  <= 8'h00;
        end else if (xdb_en) begin
            pin_d_out <= xbuf_rd_data;
            pin_d_oe  <= {8{drive_data}};
        end else begin
            pin_d_out[0]   <= alt_out.gen_chip_sel_a;
            pin_d_oe[0]    <= 1'b1;
            pin_d_out[1]   <= alt_out.gen_chip_sel_b;
            pin_d_oe[1]    <= 1'b1;
            pin_d_out[5:2] <= alt_out.gpio_out;
            pin_d_oe[5:2]  <= alt_out.gpio_oe;
            if (alt_out.irsel_on_top) begin
                pin_d_out[6] <= alt_out.infrared_select_b;
                pin_d_oe[6]  <= 1'b1;
                pin_d_out[7] <= alt_out.infrared_select_a;
                pin_d_oe[7]  <= 1'b1;
            end else begin
                // top pin then carries the id input
                pin_d_out[6] <= alt_out.gpio_e_out;
                pin_d_oe[6]  <= alt_out.gpio_e_oe;
                pin_d_out[7] <= 1'b1;
                pin_d_oe[7]  <= 1'b0;
            end
        end
    end

endmodule : xbz_glue
`default_nettype wire

// File: tb/xbz_props.sv
// checker: zero-wait, pin mux and strap properties of the glue block
`timescale 1ns/1ns
`default_nettype none
module xbz_props (
    // clock and reset
    input wire logic                  core_clk,
    input wire logic                  rst,
    // access classification
    input wire logic                  access_active,
    input wire xbz_pkg::xbz_target_t  access_target,
    input wire xbz_pkg::xbz_pp_mode_t pp_mode,
    input wire logic [7:0]            pp_second_control,
    // pins and state
    input wire logic                  zero_wait_n_out,
    input wire logic                  zero_wait_n_oe,
    input wire logic                  pp_write_n,
    input wire logic                  pp_strobe_pin_n,
    input wire logic [7:0]            pin_d_oe,
    input wire xbz_pkg::xbz_straps_t  straps,
    input wire logic                  xbuf_chip_sel_n,
    input wire xbz_pkg::xbz_alt_in_t  alt_in,
    input wire logic [7:0]            cfg1
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // access class helpers
    wire logic pp_acc  = access_active && access_target == xbz_pkg::XBZ_TGT_PP;
    wire logic cfg_acc = access_active && access_target == xbz_pkg::XBZ_TGT_CFG;
    wire logic oth_acc = access_active && access_target == xbz_pkg::XBZ_TGT_OTHR;
    // buffer selected and idle, buffer selected for a while
    sequence buf_idle_s;
        (cfg1[4] && xbuf_chip_sel_n) [*2];
    endsequence
    sequence buf_on_s;
        cfg1[4] [*3];
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    zws_quiet_a: assert property (
        cfg_acc || pp_acc && pp_mode inside {xbz_pkg::XBZ_PP_SPP,
        xbz_pkg::XBZ_PP_EPP19} |=> !zero_wait_n_oe) else $error("zws on");
    zws_ecp_a: assert property (
        pp_acc && pp_mode == xbz_pkg::XBZ_PP_ECP |=> zero_wait_n_oe)
        else $error("zws off in ecp");
    zws_epp17_a: assert property (
        pp_acc && pp_mode == xbz_pkg::XBZ_PP_EPP17 |=>
        zero_wait_n_oe == $past(pp_second_control[3])) else $error("epp17");
    zws_other_a: assert property (
        oth_acc |=> zero_wait_n_oe == $past(cfg1[0])) else $error("other");
    zws_drain_a: assert property (
        !zero_wait_n_out && (zero_wait_n_oe -> $past(access_active)))
        else $error("zws pin level");
    strobe_mux_a: assert property (
        pp_mode inside {xbz_pkg::XBZ_PP_EPP17, xbz_pkg::XBZ_PP_EPP19} |=>
        pp_strobe_pin_n == $past(pp_write_n)) else $error("strobe");
    alt_block_a: assert property (
        buf_on_s |-> alt_in == 8'hFF) else $error("alt inputs seen");
    data_hiz_a: assert property (
        buf_idle_s |-> pin_d_oe == 8'h00) else $error("data driven idle");
    strap_hold_a: assert property (
        !$past(rst) |-> $stable(straps)) else $error("straps moved");
    strap_load_a: assert property (
        $fell(rst) |-> cfg1[4] == straps.config_bits[1]) else $error("xdb");
endmodule : xbz_props
bind xbz_glue xbz_props xbz_props_i (.core_clk, .rst, .access_active,
    .access_target, .pp_mode, .pp_second_control, .zero_wait_n_out,
    .zero_wait_n_oe, .pp_write_n, .pp_strobe_pin_n, .pin_d_oe, .straps,
    .xbuf_chip_sel_n, .alt_in, .cfg1);
`default_nettype wire

// File: tb/xbz_peer.sv
// partner: x-bus peripheral on the buffer select, read and data pins
`timescale 1ns/1ns
`default_nettype none
module xbz_peer (
    // clock and requests
    input  wire logic       core_clk,
    input  wire logic       sel,
    input  wire logic       rd,
    input  wire logic [7:0] wdat,
    // design drive of the data pins
    input  wire logic [7:0] d_out,
    input  wire logic [7:0] d_oe,
    // pin levels
    output logic            cs_n,
    output logic            rd_n,
    output logic      [7:0] d
);
    logic [7:0] last = 8'h00;
    assign cs_n = !sel;
    assign rd_n = !(sel && rd);
    // undriven bits toggle so a stale value never passes
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (d_oe[i]) d[i] = d_out[i];
            else if (sel && !rd) d[i] = wdat[i];
            else d[i] = !last[i];
        end
    end
    always_ff @(posedge core_clk) last <= d;
endmodule : xbz_peer
`default_nettype wire

// File: tb/tb_xbz_glue.sv
// testbench: zero-wait, pin mux, buffer and strap scenarios
`timescale 1ns/1ns
`default_nettype none
module tb_xbz_glue;
    logic                  core_clk, rst, access_active, cfg1_wr, sel, rd;
    logic                  pp_strobe_n, pp_write_n, in_reset;
    logic                  zero_wait_n_out, zero_wait_n_oe, pp_strobe_pin_n;
    logic                  pin_cs_ring, pin_rd_id3;
    logic                  xbuf_chip_sel_n, xbuf_read_cmd_n;
    xbz_pkg::xbz_target_t  access_target;
    xbz_pkg::xbz_pp_mode_t pp_mode;
    xbz_pkg::xbz_straps_t  strap_pins, straps;
    xbz_pkg::xbz_alt_out_t alt_out;
    xbz_pkg::xbz_alt_in_t  alt_in;
    logic [7:0]            pp_second_control, cfg1_wr_data, xbuf_rd_data;
    logic [7:0]            wdat, pin_d_in, pin_d_out, pin_d_oe;
    logic [7:0]            xbuf_wr_data, cfg1;
    int                    errors, total_checks;
    xbz_glue xbz_glue_i (.core_clk, .rst, .access_active, .access_target,
        .pp_mode, .pp_second_control, .cfg1_wr_data, .cfg1_wr,
        .zero_wait_n_out, .zero_wait_n_oe, .pp_strobe_n, .pp_write_n,
        .pp_strobe_pin_n, .pin_cs_ring, .pin_rd_id3, .pin_d_in, .pin_d_out,
        .pin_d_oe, .strap_pins, .straps, .xbuf_rd_data, .xbuf_wr_data,
        .xbuf_chip_sel_n, .xbuf_read_cmd_n, .alt_out, .alt_in, .cfg1,
        .in_reset);
    xbz_peer xbz_peer_i (.core_clk, .sel, .rd, .wdat, .d_out(pin_d_out),
        .d_oe(pin_d_oe), .cs_n(pin_cs_ring), .rd_n(pin_rd_id3), .d(pin_d_in));
    // main clock supply
    // free-running clock, 100 ns period
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // compare one result, zero-extended to a byte
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // config-1 write pulse, one cycle wide
    task automatic cfg_write(input logic [7:0] d);
        @(negedge core_clk) cfg1_wr_data = d;
        cfg1_wr = 1'b1;
        @(negedge core_clk) cfg1_wr = 1'b0;
    endtask : cfg_write
    // peer request, then let the pin synchroniser settle
    task automatic peer_op(input logic s, input logic r);
        sel = s;
        rd = r;
        // direction turn plus resync of the data pins takes twelve edges
        repeat (12) @(negedge core_clk);
    endtask : peer_op
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    // watchdog well beyond the roughly 160 cycles the run needs
    initial begin
        #300000;
        errors++;
        finish_test;
    end
    initial begin
        logic e;
        {access_active, cfg1_wr, sel, rd, pp_strobe_n, pp_write_n} = 6'h03;
        access_target = xbz_pkg::XBZ_TGT_NONE;
        pp_mode = xbz_pkg::XBZ_PP_SPP;
        {pp_second_control, cfg1_wr_data, xbuf_rd_data, wdat} = 32'h0;
        alt_out = 15'h0000;
        strap_pins = 7'h45;
        errors = 0;
        total_checks = 0;
        rst = 1'b1;
        // hold long enough for the strap synchroniser
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk) strap_pins = 7'h3A;
        chk("cfg1", 8'h10, cfg1);
        chk("in_reset", 8'h00, 8'(in_reset));
        repeat (4) @(negedge core_clk);
        chk("straps", 8'h45, 8'(straps));
        // every access class, mode and gate bit
        for (int t = 0; t < 4; t++) begin
            for (int m = 0; m < 4; m++) begin
                for (int b = 0; b < 2; b++) begin
                    cfg_write({7'h08, b[0]});
                    access_active = 1'b1;
                    access_target = xbz_pkg::xbz_target_t'(t[2:0]);
                    pp_mode = xbz_pkg::xbz_pp_mode_t'(m[1:0]);
                    pp_second_control = {4'h0, b[0], 3'h0};
                    pp_write_n = b[0];
                    pp_strobe_n = !b[0];
                    @(negedge core_clk) access_active = 1'b0;
                    e = (t == 2) ? (m == 3 || m == 1 && b == 1)
                                 : (t == 3 && b == 1);
                    chk("zws_oe", 8'(e), 8'(zero_wait_n_oe));
                    chk("zws_out", 8'h00, 8'(zero_wait_n_out));
                    e = (m == 1 || m == 2) ? b[0] : !b[0];
                    chk("strobe", 8'(e), 8'(pp_strobe_pin_n));
                end
            end
        end
        // buffer read, write and idle
        xbuf_rd_data = 8'hA5;
        peer_op(1'b1, 1'b1);
        chk("rd_oe", 8'hFF, pin_d_oe);
        chk("rd_data", 8'hA5, pin_d_out);
        chk("rd_cmd", 8'h00, 8'(xbuf_read_cmd_n));
        chk("alt_in", 8'hFF, 8'(alt_in));
        wdat = 8'h3C;
        peer_op(1'b1, 1'b0);
        chk("wr_oe", 8'h00, pin_d_oe);
        chk("wr_data", 8'h3C, xbuf_wr_data);
        peer_op(1'b0, 1'b0);
        chk("idle_oe", 8'h00, pin_d_oe);
        // alternate functions on the shared pins
        cfg_write(8'h00);
        alt_out = 15'h35E0;
        peer_op(1'b1, 1'b0);
        chk("xdb_cs", 8'h01, 8'(xbuf_chip_sel_n));
        chk("ring", 8'h00, 8'(alt_in.ring_n));
        chk("alt_out", 8'h2A, {2'h0, pin_d_out[5:0]});
        chk("alt_oe", 8'h3F, {2'h0, pin_d_oe[5:0]});
        finish_test;
    end
endmodule : tb_xbz_glue
`default_nettype wire
